/* File: core/dflash_seq.sv */
// data-flash command sequencer with launch checks and irq requests
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
// Behaviour
// - erase-verify checks range erased, sets complete
// - erase-verify needs index 010 at launch
// - mode disallowed command sets access error
// - invalid global address sets access error
// - odd address sets access error
// - verify range past block end errors
// - verify read errors set status bits
// - index sets word count, then verify
// - program index outside 010..101 errors
// - program words past block end errors
// - protected area gives violation, no change
// - post-operation verify errors set status bits
// - sector erase erases and verifies sector
// - sector erase needs index 001
// - complete flag gated by its enable
// - double fault flag gated to irq
// - single fault flag gated to irq
// - irq outputs are and/or of flags
module dflash_seq (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // ecc status from the array read path
    input wire logic ecc_single_i,
    input wire logic ecc_double_i,
    // interrupt requests
    output logic cmd_irq,
    output logic err_irq
);
    flash_mem_if mif ();
    dflash_array u_array (
        .clk(clk),
        .m(mif)
    );

    logic [2:0] param_word_index_r;
    logic [15:0] command_param_word_r [0:dflash_pkg::NUM_PARAMS-1];
    logic cmd_complete_flag_r, access_error_flag_r, protect_violation_flag_r;
    logic verify_status_hi_r, verify_status_lo_r;
    logic double_fault_flag_r, single_fault_flag_r;
    logic cmd_complete_irq_en_r, double_fault_irq_en_r, single_fault_irq_en_r;
    logic [7:0] mode_allow_r;
    logic [7:0] prot_bound_r;
    logic ack_r;
    logic [31:0] dat_r;
    dflash_pkg::seq_state_e state_r;
    logic [2:0] launch_idx_r;
    logic [15:0] addr_r;
    logic [15:0] count_r;
    logic [15:0] done_r;
    logic [7:0] wait_r;
    logic [2:0] wptr_r;
    logic rd_pend_r;
    logic mem_we;
    logic [15:0] mem_wdata;

    // decode helper used by writes and reads
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic bus_req, bus_wr, launch, clr_acc, clr_fpv, clr_dfd, clr_sfd;
    assign bus_req = cyc_i & stb_i & ~ack_r;
    assign bus_wr = cyc_i & stb_i & ack_r & we_i & sel_i[0]; // at ack edge
    // writing 1 to complete starts a command; ignored while busy
    assign launch = bus_wr & hit(adr_i, dflash_pkg::ADDR_STATUS)
        & dat_i[dflash_pkg::ST_DONE] & cmd_complete_flag_r;
    assign clr_acc = bus_wr & hit(adr_i, dflash_pkg::ADDR_STATUS)
        & dat_i[dflash_pkg::ST_ACC_ERR];
    assign clr_fpv = bus_wr & hit(adr_i, dflash_pkg::ADDR_STATUS)
        & dat_i[dflash_pkg::ST_PROT_VIOL];
    assign clr_dfd = bus_wr & hit(adr_i, dflash_pkg::ADDR_ERR_STATUS)
        & dat_i[dflash_pkg::ES_DFD];
    assign clr_sfd = bus_wr & hit(adr_i, dflash_pkg::ADDR_ERR_STATUS)
        & dat_i[dflash_pkg::ES_SFD];

    // single-cycle ack, one wait-free answer per request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req;
        end
    end
    assign ack_o = ack_r;

    // parameter words and configuration; index and parameter writes refused while busy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            param_word_index_r <= 3'h0;
            cmd_complete_irq_en_r <= 1'b0;
            double_fault_irq_en_r <= 1'b0;
            single_fault_irq_en_r <= 1'b0;
            mode_allow_r <= 8'h07;
            prot_bound_r <= 8'h00;
            for (int i = 0; i < dflash_pkg::NUM_PARAMS; i++) begin
                command_param_word_r[i] <= 16'h0000;
            end
        end else if (bus_wr) begin
            if (hit(adr_i, dflash_pkg::ADDR_INDEX) && cmd_complete_flag_r) begin
                param_word_index_r <= dat_i[2:0];
            end else if (hit(adr_i, dflash_pkg::ADDR_PARAM)
                         && cmd_complete_flag_r
                         && param_word_index_r <= dflash_pkg::IDX_DATA3) begin
                command_param_word_r[param_word_index_r] <= dat_i[15:0];
            end else if (hit(adr_i, dflash_pkg::ADDR_CONFIG)) begin
                cmd_complete_irq_en_r <= dat_i[dflash_pkg::CF_DONE_IE];
            end else if (hit(adr_i, dflash_pkg::ADDR_ERR_CONFIG)) begin
                double_fault_irq_en_r <= dat_i[dflash_pkg::ES_DFD];
                single_fault_irq_en_r <= dat_i[dflash_pkg::ES_SFD];
            end else if (hit(adr_i, dflash_pkg::ADDR_MODE)) begin
                mode_allow_r <= dat_i[7:0];
            end else if (hit(adr_i, dflash_pkg::ADDR_PROT)) begin
                prot_bound_r <= dat_i[7:0];
            end
        end
    end

    // read data mux, registered with the ack
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dat_r <= 32'h0000_0000;
        end else if (bus_req && !we_i) begin
            dat_r <= 32'h0000_0000;
            if (hit(adr_i, dflash_pkg::ADDR_INDEX)) begin
                dat_r[2:0] <= param_word_index_r;
            end else if (hit(adr_i, dflash_pkg::ADDR_PARAM)) begin
                if (param_word_index_r <= dflash_pkg::IDX_DATA3) begin
                    dat_r[15:0] <= command_param_word_r[param_word_index_r];
                end
            end else if (hit(adr_i, dflash_pkg::ADDR_STATUS)) begin
                dat_r[dflash_pkg::ST_DONE] <= cmd_complete_flag_r;
                dat_r[dflash_pkg::ST_ACC_ERR] <= access_error_flag_r;
                dat_r[dflash_pkg::ST_PROT_VIOL] <= protect_violation_flag_r;
                dat_r[dflash_pkg::ST_MG1] <= verify_status_hi_r;
                dat_r[dflash_pkg::ST_MG0] <= verify_status_lo_r;
            end else if (hit(adr_i, dflash_pkg::ADDR_ERR_STATUS)) begin
                dat_r[dflash_pkg::ES_DFD] <= double_fault_flag_r;
                dat_r[dflash_pkg::ES_SFD] <= single_fault_flag_r;
            end else if (hit(adr_i, dflash_pkg::ADDR_CONFIG)) begin
                dat_r[dflash_pkg::CF_DONE_IE] <= cmd_complete_irq_en_r;
            end else if (hit(adr_i, dflash_pkg::ADDR_ERR_CONFIG)) begin
                dat_r[dflash_pkg::ES_DFD] <= double_fault_irq_en_r;
                dat_r[dflash_pkg::ES_SFD] <= single_fault_irq_en_r;
            end else if (hit(adr_i, dflash_pkg::ADDR_MODE)) begin
                dat_r[7:0] <= mode_allow_r;
            end else if (hit(adr_i, dflash_pkg::ADDR_PROT)) begin
                dat_r[7:0] <= prot_bound_r;
            end
        end
    end
    assign dat_o = dat_r;

    // launch-time checks, combinational on the loaded parameters
    logic [7:0] cmd_code;
    logic [15:0] start_a;
    logic [17:0] end_a;
    logic [2:0] nwords;
    logic chk_acc, chk_prot, is_ev, is_pg, is_se;
    always_comb begin
        cmd_code = command_param_word_r[dflash_pkg::IDX_BLOCK][15:8];
        start_a = command_param_word_r[dflash_pkg::IDX_ADDR];
        is_ev = (cmd_code == dflash_pkg::CMD_ERASE_VERIFY);
        is_pg = (cmd_code == dflash_pkg::CMD_PROGRAM);
        is_se = (cmd_code == dflash_pkg::CMD_SECTOR_ERASE);
        nwords = launch_idx_r - dflash_pkg::IDX_DATA0 + 3'h1;
        end_a = 18'(start_a);
        chk_acc = 1'b0;
        chk_prot = 1'b0;
        if (is_ev) begin
            chk_acc = (launch_idx_r != dflash_pkg::IDX_DATA0);
            // section end check, wide enough for any count
            end_a = 18'(start_a) + 18'({command_param_word_r[2], 1'b0});
            chk_acc = chk_acc | (end_a > dflash_pkg::DF_END);
        end else if (is_pg) begin
            chk_acc = (launch_idx_r < dflash_pkg::IDX_DATA0)
                    | (launch_idx_r > dflash_pkg::IDX_DATA3);
            end_a = 18'(start_a) + 18'({nwords, 1'b0});
            chk_acc = chk_acc | (end_a > dflash_pkg::DF_END);
        end else if (is_se) begin
            chk_acc = (launch_idx_r != dflash_pkg::IDX_ADDR);
        end else begin
            chk_acc = 1'b1;
        end
        if ((is_ev && !mode_allow_r[0]) || (is_pg && !mode_allow_r[1])
            || (is_se && !mode_allow_r[2])) begin
            chk_acc = 1'b1;
        end
        if (command_param_word_r[dflash_pkg::IDX_BLOCK][6:0]
            != dflash_pkg::DF_BLOCK_ID
            || {1'b0, start_a} >= dflash_pkg::DF_END) begin
            chk_acc = 1'b1;
        end
        if (start_a[0]) begin
            chk_acc = 1'b1;
        end
        // protected area below bound; never for verify
        chk_prot = (is_pg || is_se) && (start_a[15:8] < prot_bound_r);
    end

    // command sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= dflash_pkg::ST_IDLE;
            launch_idx_r <= 3'h0;
            addr_r <= 16'h0000;
            count_r <= 16'h0000;
            done_r <= 16'h0000;
            wait_r <= 8'h00;
            wptr_r <= 3'h0;
            rd_pend_r <= 1'b0;
        end else begin
            case (state_r)
                dflash_pkg::ST_IDLE: begin
                    if (launch) begin
                        state_r <= dflash_pkg::ST_CHECK;
                        launch_idx_r <= param_word_index_r;
                    end
                end
                dflash_pkg::ST_CHECK: begin
                    done_r <= 16'h0000;
                    wptr_r <= dflash_pkg::IDX_DATA0;
                    wait_r <= 8'(dflash_pkg::OP_CYCLES);
                    if (chk_acc || chk_prot) begin
                        state_r <= dflash_pkg::ST_IDLE;
                    end else if (is_ev) begin
                        addr_r <= start_a;
                        count_r <= command_param_word_r[2];
                        state_r <= dflash_pkg::ST_VERIFY;
                    end else if (is_pg) begin
                        addr_r <= start_a;
                        count_r <= {13'h0000, nwords};
                        state_r <= dflash_pkg::ST_WRITE;
                    end else begin
                        // whole sector from any inner address
                        addr_r <= start_a & dflash_pkg::SECTOR_MASK;
                        count_r <= ~dflash_pkg::SECTOR_MASK / 16'h0002 + 16'h1;
                        state_r <= dflash_pkg::ST_ERASE;
                    end
                end
                dflash_pkg::ST_WRITE, dflash_pkg::ST_ERASE: begin
                    // one word per cycle, count from index or sector size
                    if (done_r + 16'h1 == count_r) begin
                        state_r <= dflash_pkg::ST_WAIT;
                        done_r <= 16'h0000;
                    end else begin
                        done_r <= done_r + 16'h1;
                    end
                    wptr_r <= wptr_r + 3'h1;
                end
                dflash_pkg::ST_WAIT: begin
                    // program/erase pulse time before verify
                    if (wait_r == 8'h01) begin
                        state_r <= dflash_pkg::ST_VERIFY;
                    end
                    wait_r <= wait_r - 8'h01;
                    wptr_r <= dflash_pkg::IDX_DATA0;
                end
                dflash_pkg::ST_VERIFY: begin
                    // walk range; read data lags one cycle
                    rd_pend_r <= (done_r != count_r);
                    if (done_r == count_r) begin
                        if (!rd_pend_r) begin
                            state_r <= dflash_pkg::ST_IDLE;
                        end
                    end else begin
                        done_r <= done_r + 16'h1;
                        wptr_r <= wptr_r + 3'h1;
                    end
                end
                default: state_r <= dflash_pkg::ST_IDLE;
            endcase
        end
    end

    // array port drive
    logic [15:0] offs;
    assign offs = {done_r[14:0], 1'b0};
    assign mem_we = (state_r == dflash_pkg::ST_WRITE)
                  | (state_r == dflash_pkg::ST_ERASE);
    assign mem_wdata = (state_r == dflash_pkg::ST_ERASE) ? 16'hffff
                     : command_param_word_r[wptr_r];
    assign mif.we = mem_we;
    assign mif.addr = 14'((addr_r + offs) >> 1);
    assign mif.wdata = mem_wdata;

    // expected value for the word being compared
    logic [15:0] expect_r;
    logic chk_erased;
    assign chk_erased = ~is_pg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            expect_r <= 16'h0000;
        end else begin
            expect_r <= chk_erased ? 16'hffff : command_param_word_r[wptr_r];
        end
    end
    logic mismatch;
    assign mismatch = rd_pend_r & (mif.rdata != expect_r);

    // status flags; hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_complete_flag_r <= 1'b1;
            access_error_flag_r <= 1'b0;
            protect_violation_flag_r <= 1'b0;
            verify_status_hi_r <= 1'b0;
            verify_status_lo_r <= 1'b0;
        end else begin
            if (launch) begin
                cmd_complete_flag_r <= 1'b0;
                verify_status_hi_r <= 1'b0;
                verify_status_lo_r <= 1'b0;
            end else if (state_r == dflash_pkg::ST_CHECK
                         && (chk_acc || chk_prot)) begin
                cmd_complete_flag_r <= 1'b1;
            end else if (state_r == dflash_pkg::ST_VERIFY
                         && done_r == count_r && !rd_pend_r) begin
                cmd_complete_flag_r <= 1'b1;
            end
            if (state_r == dflash_pkg::ST_CHECK && chk_acc) begin
                access_error_flag_r <= 1'b1;
            end else if (clr_acc) begin
                access_error_flag_r <= 1'b0;
            end
            if (state_r == dflash_pkg::ST_CHECK && !chk_acc && chk_prot) begin
                protect_violation_flag_r <= 1'b1;
            end else if (clr_fpv) begin
                protect_violation_flag_r <= 1'b0;
            end
            if (rd_pend_r && (mismatch || ecc_single_i || ecc_double_i)) begin
                verify_status_hi_r <= 1'b1;
            end
            if (rd_pend_r && ecc_double_i) begin
                verify_status_lo_r <= 1'b1;
            end
        end
    end

    // ecc fault flags, write one to clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            double_fault_flag_r <= 1'b0;
            single_fault_flag_r <= 1'b0;
        end else begin
            if (rd_pend_r && ecc_double_i) begin
                double_fault_flag_r <= 1'b1;
            end else if (clr_dfd) begin
                double_fault_flag_r <= 1'b0;
            end
            if (rd_pend_r && ecc_single_i) begin
                single_fault_flag_r <= 1'b1;
            end else if (clr_sfd) begin
                single_fault_flag_r <= 1'b0;
            end
        end
    end

    assign cmd_irq = cmd_complete_flag_r & cmd_complete_irq_en_r;
    assign err_irq = (double_fault_flag_r & double_fault_irq_en_r)
                   | (single_fault_flag_r & single_fault_irq_en_r);
endmodule

/* File: include/dflash_pkg.sv */
// shared constants for the data-flash command sequencer
package dflash_pkg;
    // wishbone register offsets (byte addresses)
    localparam logic [7:0] ADDR_INDEX = 8'h00;
    localparam logic [7:0] ADDR_PARAM = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_ERR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;
    localparam logic [7:0] ADDR_ERR_CONFIG = 8'h14;
    localparam logic [7:0] ADDR_MODE = 8'h18;
    localparam logic [7:0] ADDR_PROT = 8'h1c;
    // command codes
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
    localparam logic [7:0] CMD_PROGRAM = 8'h11;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h12;
    // parameter indices
    localparam logic [2:0] IDX_BLOCK = 3'h0;
    localparam logic [2:0] IDX_ADDR = 3'h1;
    localparam logic [2:0] IDX_DATA0 = 3'h2;
    localparam logic [2:0] IDX_DATA3 = 3'h5;
    localparam int NUM_PARAMS = 6;
    // data-flash address window, global [22:0]
    localparam logic [6:0] DF_BLOCK_ID = 7'h10;
    localparam logic [15:0] DF_START = 16'h0000;
    localparam logic [16:0] DF_END = 17'h08000;
    localparam logic [15:0] SECTOR_MASK = 16'hff00;
    // status bit positions
    localparam int ST_DONE = 7;
    localparam int ST_ACC_ERR = 5;
    localparam int ST_PROT_VIOL = 4;
    localparam int ST_MG1 = 1;
    localparam int ST_MG0 = 0;
    localparam int ES_DFD = 1;
    localparam int ES_SFD = 0;
    localparam int CF_DONE_IE = 7;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int OP_TIME_NS = 200;
    localparam int OP_CYCLES = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_WRITE = 3'b010,
        ST_ERASE = 3'b011,
        ST_VERIFY = 3'b100,
        ST_WAIT = 3'b101
    } seq_state_e;
endpackage

/* File: include/flash_mem_if.sv */
// array access bundle between sequencer and word memory
`timescale 1ns/1ps
interface flash_mem_if;
    logic we;
    logic [13:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

/* File: core/dflash_array.sv */
// word-wide data-flash array model with registered read port
`timescale 1ns/1ps
module dflash_array (
    // clock
    input wire logic clk,
    // array port
    flash_mem_if.mem m
);
    logic [15:0] mem_r [0:255];
    logic [15:0] rdata_r;

    // write and registered read; small array keeps sim cheap
    always_ff @(posedge clk) begin
        if (m.we) begin
            mem_r[m.addr[7:0]] <= m.wdata;
        end
        rdata_r <= mem_r[m.addr[7:0]];
    end
    assign m.rdata = rdata_r;
endmodule

/* File: testbench/dflash_seq_assertions.sv */
// port-level assertions for the data-flash command sequencer
`timescale 1ns/1ps
module dflash_seq_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave side
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // ecc inputs and interrupt requests
    input wire logic ecc_single_i,
    input wire logic ecc_double_i,
    input wire logic cmd_irq,
    input wire logic err_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // write completing at this edge, low byte enabled
    logic wr_ack;
    assign wr_ack = ack_o && we_i && sel_i[0];

    // bus answer timing
    a_ack_after_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held beyond one cycle");
    a_ack_has_req: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    // outputs quiet on the first edge after reset
    a_reset_quiet: assert property (
        $rose(rst_n) |-> !ack_o && !cmd_irq && !err_irq)
        else $error("outputs active right after reset");
    // clearing all enables of a request drops it on the next cycle
    a_cmd_irq_off: assert property (
        wr_ack && adr_i == dflash_pkg::ADDR_CONFIG && !dat_i[7] |=> !cmd_irq)
        else $error("command irq survives its enable");
    a_err_irq_off: assert property (
        wr_ack && adr_i == dflash_pkg::ADDR_ERR_CONFIG && dat_i[1:0] == 2'b00
        |=> !err_irq)
        else $error("error irq survives its enables");
    // a launch from idle clears the complete flag at once
    a_launch_busy: assert property (
        wr_ack && adr_i == dflash_pkg::ADDR_STATUS && dat_i[7] && cmd_irq
        |=> !cmd_irq)
        else $error("complete still set after launch");
    // unmapped reads and unused upper bits return zero
    a_unmapped_zero: assert property (
        ack_o && !we_i && adr_i > dflash_pkg::ADDR_PROT |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (
        ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    // main scenarios reached
    c_launch: cover property (wr_ack && adr_i == dflash_pkg::ADDR_STATUS);
    c_cmd_irq: cover property ($rose(cmd_irq));
    c_err_irq: cover property ($rose(err_irq));
    c_ecc: cover property (ecc_single_i || ecc_double_i);
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the data-flash command sequencer
`timescale 1ns/1ps
module tb;
    // bench drive and dut outputs
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic ecc_s = 1'b0;
    logic ecc_d = 1'b0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack_o;
    logic cmd_irq;
    logic err_irq;
    logic [2:0] v;
    int fail_count = 0;
    int total_checks = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    dflash_seq dut (
        .clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack_o), .ecc_single_i(ecc_s), .ecc_double_i(ecc_d),
        .cmd_irq(cmd_irq), .err_irq(err_irq)
    );

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle, request held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task rdk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task load(input logic [1:0] c, input logic [6:0] bx,
              input logic [15:0] a, input logic [15:0] p2,
              input logic [2:0] last);
        wb(1'b1, dflash_pkg::ADDR_INDEX, 32'h0);
        wb(1'b1, dflash_pkg::ADDR_PARAM, {16'h0000,
            dflash_pkg::CMD_ERASE_VERIFY + c, 1'b0,
            dflash_pkg::DF_BLOCK_ID ^ bx});
        wb(1'b1, dflash_pkg::ADDR_INDEX, 32'h1);
        wb(1'b1, dflash_pkg::ADDR_PARAM, {16'h0000, a});
        for (int i = 2; i <= last; i++) begin
            wb(1'b1, dflash_pkg::ADDR_INDEX, 32'(i));
            wb(1'b1, dflash_pkg::ADDR_PARAM,
               {16'h0000, (i == 2) ? p2 : 16'($urandom)});
        end
        wb(1'b1, dflash_pkg::ADDR_STATUS, 32'h80);
    endtask

    // poll status until complete returns; bounded
    task wait_done;
        int k;
        k = 0;
        do begin
            wb(1'b0, dflash_pkg::ADDR_STATUS, 32'h0);
            k++;
        end while (rd[7] !== 1'b1 && k < 1000);
        if (k >= 1000) fail_count++;
    endtask

    // full command, final status compared, error flags cleared
    task run(input logic [1:0] c, input logic [6:0] bx,
             input logic [15:0] a, input logic [15:0] p2,
             input logic [2:0] last, input logic [31:0] e);
        load(c, bx, a, p2, last);
        wait_done;
        chk(rd, e);
        wb(1'b1, dflash_pkg::ADDR_STATUS, 32'h30);
    endtask

    // watchdog, well beyond the expected run length
    initial begin
        #500000;
        fail_count++;
        test_done;
    end

    // main sequence
    initial begin
        rd = $urandom(32'h59cf37c1);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdk(dflash_pkg::ADDR_STATUS, 32'h80);
        rdk(dflash_pkg::ADDR_MODE, 32'h7);
        rdk(dflash_pkg::ADDR_PROT, 32'h0);
        v = 3'($urandom);
        wb(1'b1, dflash_pkg::ADDR_INDEX, {29'h0, v});
        rdk(dflash_pkg::ADDR_INDEX, {29'h0, v});
        wb(1'b1, 8'h40, $urandom);
        rdk(8'h40, 32'h0);
        wb(1'b1, dflash_pkg::ADDR_CONFIG, 32'h80);
        @(negedge clk);
        chk({31'h0, cmd_irq}, 32'h1);
        $display("test registers done");
        // whole array erased before any verify
        run(2'd2, 7'h00, 16'h0000, 16'h0000, 3'd1, 32'h80);
        run(2'd2, 7'h00, 16'h7f00, 16'h0000, 3'd1, 32'h80);
        // wrong index, block, alignment and range all refused at launch
        run(2'd0, 7'h00, 16'h0100, 16'h0004, 3'd1, 32'ha0);
        run(2'd1, 7'h00, 16'h0100, 16'h1234, 3'd1, 32'ha0);
        run(2'd1, 7'h00, 16'h0100, 16'h1234, 3'd6, 32'ha0);
        run(2'd2, 7'h00, 16'h0100, 16'h0000, 3'd2, 32'ha0);
        run(2'd0, 7'h01, 16'h0100, 16'h0004, 3'd2, 32'ha0);
        run(2'd2, 7'h00, 16'h0101, 16'h0000, 3'd1, 32'ha0);
        run(2'd0, 7'h00, 16'h7ffc, 16'h0003, 3'd2, 32'ha0);
        run(2'd0, 7'h00, 16'h7ffc, 16'h0002, 3'd2, 32'h80);
        run(2'd1, 7'h00, 16'h7ffa, 16'h5a5a, 3'd5, 32'ha0);
        run(2'd3, 7'h00, 16'h0100, 16'h0000, 3'd1, 32'ha0);
        wb(1'b1, dflash_pkg::ADDR_MODE, 32'h0);
        for (int i = 0; i < 3; i++) begin
            run(2'(i), 7'h00, 16'h0100, 16'h0001,
                (i == 2) ? 3'd1 : 3'd2, 32'ha0);
        end
        wb(1'b1, dflash_pkg::ADDR_MODE, 32'h7);
        $display("test launch errors done");
        // protect boundary at sector 0x02
        wb(1'b1, dflash_pkg::ADDR_PROT, 32'h2);
        run(2'd1, 7'h00, 16'h01fe, 16'h00ff, 3'd2, 32'h90);
        run(2'd2, 7'h00, 16'h0150, 16'h0000, 3'd1, 32'h90);
        run(2'd0, 7'h00, 16'h0000, 16'h0004, 3'd2, 32'h80);
        run(2'd2, 7'h00, 16'h0266, 16'h0000, 3'd1, 32'h80);
        for (int n = 1; n <= 4; n++) begin
            run(2'd1, 7'h00, 16'(16'h0200 + 16 * n), 16'($urandom & 32'h7fff),
                3'(n + 1), 32'h80);
            run(2'd0, 7'h00, 16'(16'h0200 + 16 * n), 16'h0001,
                3'd2, 32'h82);
            run(2'd0, 7'h00, 16'(16'h0200 + 18 * n), 16'h0001,
                3'd2, 32'h80);
        end
        run(2'd0, 7'h00, 16'h0280, 16'h0008, 3'd2, 32'h80);
        $display("test program and erase done");
        // index writes refused while busy
        load(2'd2, 7'h00, 16'h0300, 16'h0000, 3'd1);
        wb(1'b1, dflash_pkg::ADDR_INDEX, 32'h5);
        rdk(dflash_pkg::ADDR_INDEX, 32'h1);
        @(negedge clk);
        chk({31'h0, cmd_irq}, 32'h0);
        wait_done;
        chk(rd, 32'h80);
        $display("test busy refusal done");
        // ecc faults during verify reads
        wb(1'b1, dflash_pkg::ADDR_ERR_CONFIG, 32'h3);
        ecc_s <= 1'b1;
        run(2'd2, 7'h00, 16'h0300, 16'h0000, 3'd1, 32'h82);
        ecc_s <= 1'b0;
        rdk(dflash_pkg::ADDR_ERR_STATUS, 32'h1);
        @(negedge clk);
        chk({31'h0, err_irq}, 32'h1);
        wb(1'b1, dflash_pkg::ADDR_ERR_STATUS, 32'h1);
        @(negedge clk);
        chk({31'h0, err_irq}, 32'h0);
        ecc_d <= 1'b1;
        run(2'd0, 7'h00, 16'h0300, 16'h0004, 3'd2, 32'h83);
        ecc_d <= 1'b0;
        rdk(dflash_pkg::ADDR_ERR_STATUS, 32'h2);
        wb(1'b1, dflash_pkg::ADDR_ERR_CONFIG, 32'h1);
        @(negedge clk);
        chk({31'h0, err_irq}, 32'h0);
        wb(1'b1, dflash_pkg::ADDR_ERR_CONFIG, 32'h0);
        wb(1'b1, dflash_pkg::ADDR_CONFIG, 32'h0);
        @(negedge clk);
        chk({31'h0, cmd_irq}, 32'h0);
        $display("test ecc and irq done");
        test_done;
    end
endmodule

// checker attached to every sequencer instance
bind dflash_seq dflash_seq_assertions u_chk (
    .clk(clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .ecc_single_i(ecc_single_i),
    .ecc_double_i(ecc_double_i), .cmd_irq(cmd_irq), .err_irq(err_irq)
);
